// file: core/pmon_pkg.sv
// Constants and types shared by the path and line performance monitor
package pmon_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W    = 32;
  localparam int ACC_W    = 16;
  localparam int PAR_W    = 4;
  localparam int RUN_W    = 4;
  localparam int NUM_SEC  = 7;
  localparam int NUM_PATH = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint SECOND_NS       = 64'd1000000000;
  localparam longint CLK_PERIOD_NS   = 64'd20;
  localparam int     SEC_TICK_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Thresholds and reset values
  // ----------------------------------------------------------------
  localparam logic [ACC_W-1:0] FAR_SES_LIMIT  = 16'h0258;
  localparam logic [ACC_W-1:0] PATH_SES_LIMIT = 16'h0960;
  localparam logic [ACC_W-1:0] LINE_SES_LIMIT = 16'h002c;
  localparam logic [RUN_W-1:0] UNAVAIL_RUN    = 4'ha;
  localparam logic [ACC_W-1:0] ACC_SAT        = 16'hffff;
  localparam logic [ACC_W-1:0] ACC_RESET      = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RESET      = 32'h0000_0000;
  localparam logic [RUN_W-1:0] RUN_RESET      = 4'h0;

  // ----------------------------------------------------------------
  // Second-counter slots and path indices
  // ----------------------------------------------------------------
  localparam int SEC_FAR_ES    = 0;
  localparam int SEC_FAR_SES   = 1;
  localparam int SEC_PATH_ES   = 2;
  localparam int SEC_PATH_SES  = 3;
  localparam int SEC_LINE_ES   = 4;
  localparam int SEC_LINE_SES  = 5;
  localparam int SEC_LINE_LOSS = 6;
  localparam int PATH_FAR_VT   = 0;
  localparam int PATH_STS      = 1;

  typedef enum logic [0:0] {
    PMON_AVAIL   = 1'b0,
    PMON_UNAVAIL = 1'b1
  } pmon_avail_t;

endpackage

// file: core/pmon_top.sv
// Per-second performance monitor for far-end VT, near-end STS path and DS3 line
`timescale 1ns/1ns
// How it works
// RULE1: Far-end VT code violations add one per REI-V error pulse, at most one per superframe.
// RULE2: A far-end VT errored second has at least one REI-V error or an RDI-V defect.
// RULE3: A far-end VT severe second has 600 or more REI-V errors or an RDI-V defect.
// RULE4: Far-end VT goes unavailable on ten severe seconds in a row and leaves on ten clean ones.
// RULE5: Near-end path code violations add the B3 parity error count, up to eight per frame.
// RULE6: A near-end path errored second has a parity error or an AIS-P, LOP-P or lower-layer defect.
// RULE7: Path failure events begin when AIS-P, LOP-P, UNEQ-P or TIM-P is declared and end on clear.
// RULE8: An ERDI-P failure also starts a path failure event when the path supports ERDI-P.
// RULE9: A near-end path severe second has 2400 or more parity errors or a path defect.
// RULE10: The STS path goes unavailable on ten severe seconds in a row and every such second counts.
// RULE11: The ten clean seconds that end an STS unavailable period are not counted.
// RULE12: Line code violations add bipolar violations and excessive-zero events.
// RULE13: A line errored second has a bipolar violation, excessive zeros or loss of signal.
// RULE14: A line severe second has 44 or more such anomalies or a line defect.
// RULE15: A line loss second holds one or more loss-of-signal defects.
// RULE16: Every second counter is judged once per one-second tick on the totals of that second.
module pmon_top
#(
  parameter int TICK_CYCLES = pmon_pkg::SEC_TICK_CYCLES
)
(
  input  wire logic                         sys_clk_i,
  input  wire logic                         reset_i,
  input  wire logic                         far_rei_err_i,
  input  wire logic                         far_rdi_i,
  input  wire logic [pmon_pkg::PAR_W-1:0]   path_parity_err_i,
  input  wire logic                         path_ais_i,
  input  wire logic                         path_lop_i,
  input  wire logic                         path_lower_defect_i,
  input  wire logic                         path_uneq_i,
  input  wire logic                         path_tim_i,
  input  wire logic                         path_erdi_fail_i,
  input  wire logic                         path_erdi_support_i,
  input  wire logic                         bipolar_violation_i,
  input  wire logic                         excessive_zeros_i,
  input  wire logic                         line_los_i,
  output logic                              sec_tick_o,
  output logic [pmon_pkg::CNT_W-1:0]        far_vt_code_violations_o,
  output logic [pmon_pkg::CNT_W-1:0]        far_vt_errored_seconds_o,
  output logic [pmon_pkg::CNT_W-1:0]        far_vt_severe_seconds_o,
  output logic [pmon_pkg::CNT_W-1:0]        far_vt_unavailable_seconds_o,
  output logic                              far_vt_unavailable_o,
  output logic [pmon_pkg::CNT_W-1:0]        near_path_code_violations_o,
  output logic [pmon_pkg::CNT_W-1:0]        near_path_errored_seconds_o,
  output logic [pmon_pkg::CNT_W-1:0]        near_path_failure_count_o,
  output logic [pmon_pkg::CNT_W-1:0]        near_path_severe_seconds_o,
  output logic [pmon_pkg::CNT_W-1:0]        near_path_unavailable_seconds_o,
  output logic                              near_path_unavailable_o,
  output logic [pmon_pkg::CNT_W-1:0]        line_code_violations_o,
  output logic [pmon_pkg::CNT_W-1:0]        line_errored_seconds_o,
  output logic [pmon_pkg::CNT_W-1:0]        line_severe_seconds_o,
  output logic [pmon_pkg::CNT_W-1:0]        line_signal_loss_seconds_o
);
  import pmon_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);

  // ----------------------------------------------------------------
  // One-second tick
  // ----------------------------------------------------------------
  // The tick is registered so it shows with the counters that it announces;
  // with TICK_CYCLES of 1 it would stay high and close a second on every edge
  logic [TW-1:0] tick_cnt;
  wire           tick_last = (tick_cnt == TW'(TICK_CYCLES - 1));
  wire  [TW-1:0] next_tick_cnt = tick_last ? '0 : tick_cnt + TW'(1);

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tick_cnt   <= '0;
      sec_tick_o <= 1'b0;
    end
    else
    begin
      tick_cnt   <= next_tick_cnt;
      sec_tick_o <= tick_last;
    end
  end

  // ----------------------------------------------------------------
  // Per-second accumulators
  // ----------------------------------------------------------------
  // Events in the tick cycle itself belong to the second just ending,
  // so the verdicts look at the sums including the current cycle.
  logic [ACC_W-1:0] far_acc;
  logic [ACC_W-1:0] path_acc;
  logic [ACC_W-1:0] line_acc;
  logic             far_rdi_seen;
  logic             path_def_seen;
  logic             line_los_seen;

  wire [ACC_W:0]   far_wide  = {1'b0, far_acc} + (ACC_W+1)'(far_rei_err_i);
  wire [ACC_W:0]   path_wide = {1'b0, path_acc} + (ACC_W+1)'(path_parity_err_i);
  wire [1:0]       line_hits = {1'b0, bipolar_violation_i} + {1'b0, excessive_zeros_i};
  wire [ACC_W:0]   line_wide = {1'b0, line_acc} + (ACC_W+1)'(line_hits);
  // Saturation keeps a flood of errors from wrapping below a threshold
  wire [ACC_W-1:0] far_sum   = far_wide[ACC_W] ? ACC_SAT : far_wide[ACC_W-1:0];
  wire [ACC_W-1:0] path_sum  = path_wide[ACC_W] ? ACC_SAT : path_wide[ACC_W-1:0];
  wire [ACC_W-1:0] line_sum  = line_wide[ACC_W] ? ACC_SAT : line_wide[ACC_W-1:0];

  wire path_defect   = path_ais_i | path_lop_i | path_lower_defect_i;
  wire far_rdi_sum   = far_rdi_seen | far_rdi_i;
  wire path_def_sum  = path_def_seen | path_defect;
  wire line_los_sum  = line_los_seen | line_los_i;

  // Each accumulator restarts on the closing edge, so no event is lost or counted twice
  wire [ACC_W-1:0] next_far_acc  = tick_last ? ACC_RESET : far_sum;
  wire [ACC_W-1:0] next_path_acc = tick_last ? ACC_RESET : path_sum;
  wire [ACC_W-1:0] next_line_acc = tick_last ? ACC_RESET : line_sum;
  wire             next_far_rdi  = ~tick_last & far_rdi_sum;
  wire             next_path_def = ~tick_last & path_def_sum;
  wire             next_line_los = ~tick_last & line_los_sum;

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      far_acc       <= ACC_RESET;
      path_acc      <= ACC_RESET;
      line_acc      <= ACC_RESET;
      far_rdi_seen  <= 1'b0;
      path_def_seen <= 1'b0;
      line_los_seen <= 1'b0;
    end
    else
    begin
      far_acc       <= next_far_acc; // RULE16
      path_acc      <= next_path_acc;
      line_acc      <= next_line_acc;
      far_rdi_seen  <= next_far_rdi;
      path_def_seen <= next_path_def;
      line_los_seen <= next_line_los;
    end
  end

  // ----------------------------------------------------------------
  // Second verdicts
  // ----------------------------------------------------------------
  // Verdicts matter only on the closing edge; in between they just follow the sums
  logic [NUM_SEC-1:0] sec_flag;

  assign sec_flag[SEC_FAR_ES]    = (far_sum != ACC_RESET) | far_rdi_sum; // RULE2
  assign sec_flag[SEC_FAR_SES]   = (far_sum >= FAR_SES_LIMIT) | far_rdi_sum; // RULE3
  assign sec_flag[SEC_PATH_ES]   = (path_sum != ACC_RESET) | path_def_sum; // RULE6
  assign sec_flag[SEC_PATH_SES]  = (path_sum >= PATH_SES_LIMIT) | path_def_sum; // RULE9
  assign sec_flag[SEC_LINE_ES]   = (line_sum != ACC_RESET) | line_los_sum; // RULE13
  assign sec_flag[SEC_LINE_SES]  = (line_sum >= LINE_SES_LIMIT) | line_los_sum; // RULE14
  assign sec_flag[SEC_LINE_LOSS] = line_los_sum; // RULE15

  // Counts wrap at full width; readers take differences between snapshots
  logic [CNT_W-1:0] sec_cnt [NUM_SEC];

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SEC; gs++)
    begin : g_sec
      always_ff @(posedge sys_clk_i or posedge reset_i)
      begin
        if (reset_i)
          sec_cnt[gs] <= CNT_RESET;
        else if (tick_last && sec_flag[gs])
          sec_cnt[gs] <= sec_cnt[gs] + CNT_W'(1); // RULE16
      end
    end
  endgenerate

  // Outputs read the counter flops directly, with no logic in between
  assign far_vt_errored_seconds_o    = sec_cnt[SEC_FAR_ES];
  assign far_vt_severe_seconds_o     = sec_cnt[SEC_FAR_SES];
  assign near_path_errored_seconds_o = sec_cnt[SEC_PATH_ES];
  assign near_path_severe_seconds_o  = sec_cnt[SEC_PATH_SES];
  assign line_errored_seconds_o      = sec_cnt[SEC_LINE_ES];
  assign line_severe_seconds_o       = sec_cnt[SEC_LINE_SES];
  assign line_signal_loss_seconds_o  = sec_cnt[SEC_LINE_LOSS];

  // ----------------------------------------------------------------
  // Unavailability, one machine per path
  // ----------------------------------------------------------------
  // Seconds are held pending while a clean run may still end the period;
  // a severe second books them, a full clean run throws them away.
  // Entry books at once the ten severe seconds that led to it.
  wire [NUM_PATH-1:0] path_ses = {sec_flag[SEC_PATH_SES], sec_flag[SEC_FAR_SES]};

  pmon_avail_t      avail_state [NUM_PATH];
  logic [RUN_W-1:0] run_len     [NUM_PATH];
  logic [RUN_W-1:0] pend_len    [NUM_PATH];
  logic [CNT_W-1:0] uas_cnt     [NUM_PATH];

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PATH; gp++)
    begin : g_path
      pmon_avail_t      next_state;
      logic [RUN_W-1:0] next_run;
      logic [RUN_W-1:0] next_pend;
      logic [CNT_W-1:0] next_uas;
      wire              run_done = (run_len[gp] == UNAVAIL_RUN - RUN_W'(1));

      always_comb
      begin
        next_state = avail_state[gp];
        next_run   = run_len[gp];
        next_pend  = pend_len[gp];
        next_uas   = uas_cnt[gp];
        unique case (avail_state[gp])
          PMON_AVAIL:
          begin
            next_pend = RUN_RESET;
            if (!path_ses[gp])
              next_run = RUN_RESET;
            else if (run_done)
            begin
              next_state = PMON_UNAVAIL; // RULE4 RULE10
              next_run   = RUN_RESET;
              next_uas   = uas_cnt[gp] + CNT_W'(UNAVAIL_RUN);
            end
            else
              next_run = run_len[gp] + RUN_W'(1);
          end
          PMON_UNAVAIL:
          begin
            if (path_ses[gp])
            begin
              next_run  = RUN_RESET; // RULE10
              next_pend = RUN_RESET;
              next_uas  = uas_cnt[gp] + CNT_W'(pend_len[gp]) + CNT_W'(1);
            end
            else if (run_done)
            begin
              next_state = PMON_AVAIL; // RULE11
              next_run   = RUN_RESET;
              next_pend  = RUN_RESET;
            end
            else
            begin
              next_run  = run_len[gp] + RUN_W'(1);
              next_pend = pend_len[gp] + RUN_W'(1);
            end
          end
        endcase
      end

      always_ff @(posedge sys_clk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          avail_state[gp] <= PMON_AVAIL;
          run_len[gp]     <= RUN_RESET;
          pend_len[gp]    <= RUN_RESET;
          uas_cnt[gp]     <= CNT_RESET;
        end
        else if (tick_last)
        begin
          avail_state[gp] <= next_state; // RULE16
          run_len[gp]     <= next_run;
          pend_len[gp]    <= next_pend;
          uas_cnt[gp]     <= next_uas;
        end
      end
    end
  endgenerate

  assign far_vt_unavailable_seconds_o    = uas_cnt[PATH_FAR_VT];
  assign near_path_unavailable_seconds_o = uas_cnt[PATH_STS];
  assign far_vt_unavailable_o            = (avail_state[PATH_FAR_VT] == PMON_UNAVAIL);
  assign near_path_unavailable_o         = (avail_state[PATH_STS] == PMON_UNAVAIL);

  // ----------------------------------------------------------------
  // Running violation counts and failure events
  // ----------------------------------------------------------------
  // A lower-layer defect errs seconds but is not a failure, so it stays out of this OR
  logic fail_prev;
  wire  path_fail_declared = path_ais_i | path_lop_i | path_uneq_i | path_tim_i; // RULE7
  wire  erdi_fail_counted  = path_erdi_support_i & path_erdi_fail_i; // RULE8
  wire  fail_now           = path_fail_declared | erdi_fail_counted;
  // An event that spans a tick counts once, in the second where it begins
  wire  fail_start         = fail_now & ~fail_prev;

  // Violation totals run freely; the per-second view is left to whoever reads them
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      far_vt_code_violations_o    <= CNT_RESET;
      near_path_code_violations_o <= CNT_RESET;
      line_code_violations_o      <= CNT_RESET;
      near_path_failure_count_o   <= CNT_RESET;
      fail_prev                   <= 1'b0;
    end
    else
    begin
      far_vt_code_violations_o    <= far_vt_code_violations_o + CNT_W'(far_rei_err_i); // RULE1
      near_path_code_violations_o <= near_path_code_violations_o + CNT_W'(path_parity_err_i); // RULE5
      line_code_violations_o      <= line_code_violations_o + CNT_W'(line_hits); // RULE12
      near_path_failure_count_o   <= near_path_failure_count_o + CNT_W'(fail_start); // RULE7
      fail_prev                   <= fail_now;
    end
  end

endmodule // pmon_top

// file: verif/pmon_properties.sv
// Concurrent checks on the monitor's ports
`timescale 1ns/1ns
module pmon_properties
  import pmon_pkg::*;
#(
  parameter int TICK_CYCLES = 640
)
(
  input wire logic             sys_clk_i,
  input wire logic             reset_i,
  input wire logic             far_rei_err_i,
  input wire logic [PAR_W-1:0] path_parity_err_i,
  input wire logic             path_ais_i,
  input wire logic             path_lop_i,
  input wire logic             path_uneq_i,
  input wire logic             path_tim_i,
  input wire logic             path_erdi_fail_i,
  input wire logic             path_erdi_support_i,
  input wire logic             bipolar_violation_i,
  input wire logic             excessive_zeros_i,
  input wire logic             sec_tick_o,
  input wire logic [CNT_W-1:0] far_vt_code_violations_o,
  input wire logic [CNT_W-1:0] far_vt_unavailable_seconds_o,
  input wire logic             far_vt_unavailable_o,
  input wire logic [CNT_W-1:0] near_path_code_violations_o,
  input wire logic [CNT_W-1:0] near_path_failure_count_o,
  input wire logic [CNT_W-1:0] near_path_unavailable_seconds_o,
  input wire logic             near_path_unavailable_o,
  input wire logic [CNT_W-1:0] line_code_violations_o,
  input wire logic [CNT_W-1:0] line_errored_seconds_o,
  input wire logic [CNT_W-1:0] line_severe_seconds_o,
  input wire logic [CNT_W-1:0] line_signal_loss_seconds_o
);
  int   tick_gap;
  logic fail_any;
  assign fail_any = path_ais_i | path_lop_i | path_uneq_i | path_tim_i | (path_erdi_fail_i & path_erdi_support_i);
  // Gap restarts on each tick, so a drifting second shows at once
  always_ff @(posedge sys_clk_i or posedge reset_i)
    if (reset_i)
      tick_gap <= 0;
    else
      tick_gap <= sec_tick_o ? 1 : tick_gap + 1;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_enter(u);
    !u ##1 u;
  endsequence
  AST_TICK_PERIOD: assert property (sec_tick_o == (tick_gap == TICK_CYCLES))
    else $error("second tick off period");
  AST_FAR_CV: assert property (1'b1 |=> far_vt_code_violations_o ==
    $past(far_vt_code_violations_o) + $past(far_rei_err_i)) else $error("far code violation step wrong");
  AST_PATH_CV: assert property (1'b1 |=> near_path_code_violations_o ==
    $past(near_path_code_violations_o) + $past(path_parity_err_i)) else $error("path code violation step wrong");
  AST_LINE_CV: assert property (1'b1 |=> line_code_violations_o == $past(line_code_violations_o) +
    $past(bipolar_violation_i) + $past(excessive_zeros_i)) else $error("line code violation step wrong");
  AST_FAIL_EDGE: assert property (1'b1 |=> near_path_failure_count_o ==
    $past(near_path_failure_count_o) + ($past(fail_any) & !$past(fail_any, 2))) else $error("failure count wrong");
  AST_FAR_ENTER: assert property (s_enter(far_vt_unavailable_o) |-> sec_tick_o &&
    far_vt_unavailable_seconds_o == $past(far_vt_unavailable_seconds_o) + 10) else $error("far entry wrong");
  AST_PATH_ENTER: assert property (s_enter(near_path_unavailable_o) |-> sec_tick_o &&
    near_path_unavailable_seconds_o == $past(near_path_unavailable_seconds_o) + 10) else $error("path entry wrong");
  AST_PATH_EXIT: assert property ($fell(near_path_unavailable_o) |->
    sec_tick_o && $stable(near_path_unavailable_seconds_o)) else $error("path exit counted");
  AST_LOSS_MARKS: assert property (sec_tick_o && $changed(line_signal_loss_seconds_o) |->
    $changed(line_errored_seconds_o) && $changed(line_severe_seconds_o)) else $error("loss second not marked");
endmodule // pmon_properties

bind pmon_top pmon_properties #(.TICK_CYCLES(TICK_CYCLES)) chk (.*);

// file: verif/pmon_detect_model.sv
// Behavioural model of the overhead and defect detectors feeding the monitor
`timescale 1ns/1ns
module pmon_detect_model
  import pmon_pkg::*;
#(
  parameter int T = 640
)
(
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic [11:0] prof_nf,
  input  wire logic [11:0] prof_np,
  input  wire logic [11:0] prof_nl,
  input  wire logic [11:0] prof_ne,
  input  wire logic [8:0]  prof_d,
  output logic             far_rei_err_i,
  output logic             far_rdi_i,
  output logic [PAR_W-1:0] path_parity_err_i,
  output logic             path_ais_i,
  output logic             path_lop_i,
  output logic             path_lower_defect_i,
  output logic             path_uneq_i,
  output logic             path_tim_i,
  output logic             path_erdi_fail_i,
  output logic             path_erdi_support_i,
  output logic             bipolar_violation_i,
  output logic             excessive_zeros_i,
  output logic             line_los_i
);
  int i;
  // Events sit early in each second, so none spills past the closing edge
  always @(negedge sys_clk_i or posedge reset_i)
    if (reset_i)
    begin
      i <= 0;
      {far_rei_err_i, path_parity_err_i, bipolar_violation_i, excessive_zeros_i} <= '0;
      {path_erdi_support_i, path_erdi_fail_i, path_tim_i, path_uneq_i, line_los_i} <= '0;
      {path_lower_defect_i, path_lop_i, path_ais_i, far_rdi_i} <= '0;
    end
    else
    begin
      far_rei_err_i <= (i < prof_nf);
      path_parity_err_i <= (8 * i >= prof_np) ? 4'h0 : (prof_np - 8 * i > 8) ? 4'h8 : 4'(prof_np - 8 * i);
      bipolar_violation_i <= (i < prof_nl);
      excessive_zeros_i <= (i < prof_ne);
      {path_erdi_support_i, path_erdi_fail_i, path_tim_i, path_uneq_i, line_los_i,
       path_lower_defect_i, path_lop_i, path_ais_i, far_rdi_i} <= (i >= 1 && i <= 5) ? prof_d : 9'h000;
      i <= (i == T - 1) ? 0 : i + 1;
    end
endmodule // pmon_detect_model

// file: verif/pmon_top_bench.sv
// Self-checking bench for the performance monitor
`timescale 1ns/1ns
module pmon_top_bench;
  import pmon_pkg::*;
  localparam int T = 640;
  typedef logic [14:0][CNT_W-1:0] pmon_snap_t;
  logic sys_clk_i, reset_i, far_rei_err_i, far_rdi_i, path_ais_i, path_lop_i, path_lower_defect_i, path_uneq_i;
  logic path_tim_i, path_erdi_fail_i, path_erdi_support_i, bipolar_violation_i, excessive_zeros_i, line_los_i;
  logic [PAR_W-1:0] path_parity_err_i;
  logic sec_tick_o, far_vt_unavailable_o, near_path_unavailable_o;
  logic [CNT_W-1:0] far_vt_code_violations_o, far_vt_errored_seconds_o, far_vt_severe_seconds_o;
  logic [CNT_W-1:0] far_vt_unavailable_seconds_o, near_path_code_violations_o, near_path_errored_seconds_o;
  logic [CNT_W-1:0] near_path_failure_count_o, near_path_severe_seconds_o, near_path_unavailable_seconds_o;
  logic [CNT_W-1:0] line_code_violations_o, line_errored_seconds_o, line_severe_seconds_o, line_signal_loss_seconds_o;
  logic [11:0] prof_nf, prof_np, prof_nl, prof_ne;
  logic [8:0]  prof_d;
  logic [15:0] r;
  pmon_snap_t  e, seen, notes[$];
  int          run [0:15];
  int          miscompares, checks;

  pmon_top #(.TICK_CYCLES(T)) DUT (.*);
  pmon_detect_model #(.T(T)) partner (.*);

  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task check(input pmon_snap_t got, input pmon_snap_t want);
    checks++;
    if (got !== want)
    begin
      miscompares++;
      $display("FAIL t=%0t seen=%h want=%h", $time, got, want);
    end
  endtask

  task end_sim;
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Expectation model
  // ----------------------------------------------------------------
  // Pending clean seconds are paid only if a severe second interrupts the exit run
  task automatic unav(input int b, input bit s);
    logic u;
    int   n;
    u = e[b+1][0];
    n = (s != u) ? run[b] + 1 : 0;
    e[b] += (u && s) ? 1 + run[b] : (!u && n == 10) ? 10 : 0;
    e[b+1] = (n == 10) ? 32'(!u) : 32'(u);
    run[b] = (n == 10) ? 0 : n;
  endtask

  task automatic sec(input int nf, input int np, input int nl, input int ne, input logic [8:0] d);
    bit sf, sp;
    {prof_nf, prof_np, prof_nl, prof_ne, prof_d} = {12'(nf), 12'(np), 12'(nl), 12'(ne), d};
    sf = nf >= 600 || d[0];
    sp = np >= 2400 || |d[3:1];
    e[0] += nf;
    e[1] += (nf > 0 || d[0]);
    e[2] += sf;
    e[5] += np;
    e[6] += (np > 0 || |d[3:1]);
    e[7] += (|d[2:1] || |d[6:5] || (d[7] && d[8]));
    e[8] += sp;
    e[11] += nl + ne;
    e[12] += (nl + ne > 0 || d[4]);
    e[13] += (nl + ne >= 44 || d[4]);
    e[14] += d[4];
    unav(3, sf);
    unav(9, sp);
    notes.push_back(e);
    repeat (T) @(posedge sys_clk_i);
  endtask

  always @(negedge sys_clk_i)
    if (sec_tick_o === 1'b1)
    begin
      seen = {line_signal_loss_seconds_o, line_severe_seconds_o, line_errored_seconds_o, line_code_violations_o,
              31'h0, near_path_unavailable_o, near_path_unavailable_seconds_o, near_path_severe_seconds_o,
              near_path_failure_count_o, near_path_errored_seconds_o, near_path_code_violations_o, 31'h0,
              far_vt_unavailable_o, far_vt_unavailable_seconds_o, far_vt_severe_seconds_o,
              far_vt_errored_seconds_o, far_vt_code_violations_o};
      check(seen, notes.size() ? notes.pop_front() : 'x);
    end

  initial
  begin
    #(64'd20 * T * 70);
    miscompares++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    reset_i = 1'b1;
    {prof_nf, prof_np, prof_nl, prof_ne, prof_d} = '0;
    e = '0;
    r = 16'h0008;
    run = '{default: 0};
    repeat (10) @(negedge sys_clk_i);
    reset_i <= 1'b0;
    sec(599, 2399, 43, 0, 9'h000);
    sec(600, 2400, 22, 22, 9'h000);
    for (int k = 0; k < 9; k++)
      sec(0, 0, 0, 0, 9'h001 << k);
    sec(0, 0, 0, 0, 9'h180);
    repeat (10) sec(0, 0, 0, 0, 9'h003);
    repeat (3) sec(0, 0, 0, 0, 9'h000);
    sec(1, 8, 1, 0, 9'h003);
    repeat (10) sec(0, 0, 0, 0, 9'h000);
    repeat (9) sec(0, 0, 0, 0, 9'h00c);
    sec(0, 0, 0, 0, 9'h000);
    repeat (8)
    begin
      r = lfsr(r);
      sec(r % 640, r % 2500, r[5:0], r[9:4] % 30, (r[15:13] == 3'h0) ? r[8:0] : 9'h000);
    end
    repeat (3) @(negedge sys_clk_i);
    check(pmon_snap_t'(notes.size()), '0);
    end_sim();
  end
endmodule // pmon_top_bench
